/* flag_sync.sv */
`timescale 1ns/1ps
module flag_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire measure_pkg::flag_s d_i,
	output logic [2:0] q_o
);

	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
	} sync_state_s;

	sync_state_s s_q;
	sync_state_s s_d;

	// Two-stage synchroniser; only the second stage is visible outside
	always_comb begin
		s_d = s_q;
		s_d.meta = d_i;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.sync;

endmodule

/* measure_pkg.sv */
// How it works
// RULE1: Period update request bit seven, self clearing.
// RULE2: Width update request bit six, self clearing.
// RULE3: Counter reset request bit five, self clearing.
// RULE4: Bit two shows counter incrementing.
// RULE5: Bit one shows window open state.
// RULE6: Bit zero shows acquisition in progress.
// RULE7: Bits four, three read zero; reset zero.
// RULE8: Zero writes ignored; request holds until done.
package measure_pkg;

////////////////////////////////////////////////////////////////////////////////
// Register map, byte addresses on a 32-bit Wishbone bus
localparam logic [3:0] ADDR_W = 4'h4;
localparam logic [3:0] STATUS_REQ_ADDR = 4'h0;
localparam logic [3:0] COMPLETE_ADDR = 4'h4;
localparam logic [7:0] STATUS_RESET = 8'h00;

////////////////////////////////////////////////////////////////////////////////
// Field positions in measure_status_request
localparam int PERIOD_REQ_BIT = 7;
localparam int WIDTH_REQ_BIT = 6;
localparam int COUNT_RST_BIT = 5;
localparam int COUNT_ACT_BIT = 2;
localparam int WINDOW_BIT = 1;
localparam int ACQUIRE_BIT = 0;
localparam logic [7:0] REQ_MASK = 8'hE0;

////////////////////////////////////////////////////////////////////////////////
// Core-side signal groups
typedef struct packed {
	logic period_buffer_update_req;
	logic width_buffer_update_req;
	logic count_reset_req;
} req_s;

typedef struct packed {
	logic period_done;
	logic width_done;
	logic count_reset_done;
} done_s;

typedef struct packed {
	logic count_active;
	logic window_open;
	logic acquire_active;
} flag_s;

endpackage

/* measure_timer_status.sv */
`timescale 1ns/1ps
module measure_timer_status (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire measure_pkg::done_s done_i,
	input wire measure_pkg::flag_s flag_i,
	output measure_pkg::req_s req_o
);

	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
		logic period_req;
		logic width_req;
		logic count_rst_req;
	} state_s;

	state_s s_q;
	state_s s_d;
	logic [2:0] flag_sync_w;
	logic access;
	logic wr_lane0;
	logic [7:0] status_view;
	logic [7:0] done_view;
	logic set_period;
	logic set_width;
	logic set_count;
	logic read_status;
	logic read_complete;

	////////////////////////////////////////////////////////////////////////////
	// Flags arrive from the counter core, which may run on another clock
	flag_sync u_flag_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(flag_i),
		.q_o(flag_sync_w)
	);

	assign access = wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err;
	assign wr_lane0 = access && wb_we_i && wb_sel_i[0]
		&& (wb_adr_i == measure_pkg::STATUS_REQ_ADDR);

	// Decoded strobes, shared by the checks below
	assign set_period = wr_lane0 && wb_dat_i[measure_pkg::PERIOD_REQ_BIT];
	assign set_width = wr_lane0 && wb_dat_i[measure_pkg::WIDTH_REQ_BIT];
	assign set_count = wr_lane0 && wb_dat_i[measure_pkg::COUNT_RST_BIT];
	assign read_status = access && !wb_we_i && (wb_adr_i == measure_pkg::STATUS_REQ_ADDR);
	assign read_complete = access && !wb_we_i && (wb_adr_i == measure_pkg::COMPLETE_ADDR);

	// Bits four and three stay zero by construction
	always_comb begin
		status_view = measure_pkg::STATUS_RESET; // RULE7
		status_view[measure_pkg::PERIOD_REQ_BIT] = s_q.period_req;
		status_view[measure_pkg::WIDTH_REQ_BIT] = s_q.width_req;
		status_view[measure_pkg::COUNT_RST_BIT] = s_q.count_rst_req;
		status_view[measure_pkg::COUNT_ACT_BIT] = flag_sync_w[2]; // RULE4
		status_view[measure_pkg::WINDOW_BIT] = flag_sync_w[1]; // RULE5
		status_view[measure_pkg::ACQUIRE_BIT] = flag_sync_w[0]; // RULE6
	end

	always_comb begin
		done_view = measure_pkg::STATUS_RESET;
		done_view[measure_pkg::PERIOD_REQ_BIT] = done_i.period_done;
		done_view[measure_pkg::WIDTH_REQ_BIT] = done_i.width_done;
		done_view[measure_pkg::COUNT_RST_BIT] = done_i.count_reset_done;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave and request bits; a new set beats a done pulse in the same cycle
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.err = 1'b0;
		if (done_i.period_done) begin
			s_d.period_req = 1'b0; // RULE1
		end
		if (done_i.width_done) begin
			s_d.width_req = 1'b0; // RULE2
		end
		if (done_i.count_reset_done) begin
			s_d.count_rst_req = 1'b0; // RULE3
		end
		if (wr_lane0) begin
			// Writing zero leaves a pending request alone
			if (wb_dat_i[measure_pkg::PERIOD_REQ_BIT]) begin
				s_d.period_req = 1'b1; // RULE8
			end
			if (wb_dat_i[measure_pkg::WIDTH_REQ_BIT]) begin
				s_d.width_req = 1'b1; // RULE8
			end
			if (wb_dat_i[measure_pkg::COUNT_RST_BIT]) begin
				s_d.count_rst_req = 1'b1; // RULE8
			end
		end
		if (access) begin
			case (wb_adr_i)
				measure_pkg::STATUS_REQ_ADDR: begin
					s_d.ack = 1'b1;
					s_d.rdata = {24'h000000, status_view};
				end
				measure_pkg::COMPLETE_ADDR: begin
					s_d.ack = 1'b1;
					s_d.rdata = {24'h000000, done_view};
				end
				default: begin
					s_d.err = 1'b1;
					s_d.rdata = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0; // RULE7
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_ack_o = s_q.ack;
	assign wb_err_o = s_q.err;
	assign wb_dat_o = s_q.rdata;
	assign req_o.period_buffer_update_req = s_q.period_req;
	assign req_o.width_buffer_update_req = s_q.width_req;
	assign req_o.count_reset_req = s_q.count_rst_req;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_period_set;
		@(posedge clk_i) disable iff (rst_i)
		set_period |=> req_o.period_buffer_update_req;
	endproperty
	a_period_set: assert property (p_period_set) else $error("period request not set"); // RULE1

	property p_period_clr;
		@(posedge clk_i) disable iff (rst_i)
		done_i.period_done && !set_period |=> !req_o.period_buffer_update_req;
	endproperty
	a_period_clr: assert property (p_period_clr) else $error("period request not cleared"); // RULE1

	property p_width_cycle;
		@(posedge clk_i) disable iff (rst_i)
		done_i.width_done && !set_width |=> !req_o.width_buffer_update_req;
	endproperty
	a_width_cycle: assert property (p_width_cycle) else $error("width request not cleared"); // RULE2

	property p_rst_set;
		@(posedge clk_i) disable iff (rst_i)
		set_count |=> req_o.count_reset_req;
	endproperty
	a_rst_set: assert property (p_rst_set) else $error("count reset request not set"); // RULE3

	property p_active_flag;
		@(posedge clk_i) disable iff (rst_i)
		read_status |=> wb_dat_o[measure_pkg::COUNT_ACT_BIT] == $past(flag_sync_w[2]);
	endproperty
	a_active_flag: assert property (p_active_flag) else $error("count active flag wrong"); // RULE4

	property p_window_flag;
		@(posedge clk_i) disable iff (rst_i)
		$rose(flag_i.window_open) ##1 flag_i.window_open |=> flag_sync_w[1];
	endproperty
	a_window_flag: assert property (p_window_flag) else $error("window flag lags"); // RULE5

	property p_acq_flag;
		@(posedge clk_i) disable iff (rst_i)
		read_status |=> wb_dat_o[measure_pkg::ACQUIRE_BIT] == $past(flag_sync_w[0]);
	endproperty
	a_acq_flag: assert property (p_acq_flag) else $error("acquire flag wrong"); // RULE6

	property p_unimpl;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> wb_dat_o[4:3] == 2'b00;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented bits nonzero"); // RULE7

	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		req_o.width_buffer_update_req && !done_i.width_done |=> req_o.width_buffer_update_req;
	endproperty
	a_hold: assert property (p_hold) else $error("width request dropped early"); // RULE8

	// Each request bit follows its own set and clear, apart from the others
	property p_width_set;
		@(posedge clk_i) disable iff (rst_i)
		set_width |=> req_o.width_buffer_update_req;
	endproperty
	a_width_set: assert property (p_width_set) else $error("width request not set"); // RULE2

	property p_rst_clr;
		@(posedge clk_i) disable iff (rst_i)
		done_i.count_reset_done && !set_count |=> !req_o.count_reset_req;
	endproperty
	a_rst_clr: assert property (p_rst_clr) else $error("count reset not cleared"); // RULE3

	// A write meeting a completion in one cycle must not be lost to it
	property p_period_wins;
		@(posedge clk_i) disable iff (rst_i)
		set_period && done_i.period_done |=> req_o.period_buffer_update_req;
	endproperty
	a_period_wins: assert property (p_period_wins) else $error("period set lost"); // RULE1

	// Pending requests hold until the core reports completion
	property p_period_hold;
		@(posedge clk_i) disable iff (rst_i)
		req_o.period_buffer_update_req && !done_i.period_done |=>
			req_o.period_buffer_update_req;
	endproperty
	a_period_hold: assert property (p_period_hold) else $error("period request lost"); // RULE8

	property p_rst_hold;
		@(posedge clk_i) disable iff (rst_i)
		req_o.count_reset_req && !done_i.count_reset_done |=> req_o.count_reset_req;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("count reset lost"); // RULE8

	// Only a one written to byte lane 0 of the status word raises a request
	property p_period_quiet;
		@(posedge clk_i) disable iff (rst_i)
		!req_o.period_buffer_update_req && !set_period |=>
			!req_o.period_buffer_update_req;
	endproperty
	a_period_quiet: assert property (p_period_quiet) else $error("period request rose"); // RULE8

	property p_width_quiet;
		@(posedge clk_i) disable iff (rst_i)
		!req_o.width_buffer_update_req && !set_width |=> !req_o.width_buffer_update_req;
	endproperty
	a_width_quiet: assert property (p_width_quiet) else $error("width request rose"); // RULE8

	property p_rst_quiet;
		@(posedge clk_i) disable iff (rst_i)
		!req_o.count_reset_req && !set_count |=> !req_o.count_reset_req;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("count reset rose"); // RULE8

	// Read data carries the bits as they stood at the taken edge
	property p_period_read;
		@(posedge clk_i) disable iff (rst_i)
		read_status |=>
			wb_dat_o[measure_pkg::PERIOD_REQ_BIT] == $past(req_o.period_buffer_update_req);
	endproperty
	a_period_read: assert property (p_period_read) else $error("period bit read wrong"); // RULE1

	property p_width_read;
		@(posedge clk_i) disable iff (rst_i)
		read_status |=>
			wb_dat_o[measure_pkg::WIDTH_REQ_BIT] == $past(req_o.width_buffer_update_req);
	endproperty
	a_width_read: assert property (p_width_read) else $error("width bit read wrong"); // RULE2

	property p_rst_read;
		@(posedge clk_i) disable iff (rst_i)
		read_status |=> wb_dat_o[measure_pkg::COUNT_RST_BIT] == $past(req_o.count_reset_req);
	endproperty
	a_rst_read: assert property (p_rst_read) else $error("reset bit read wrong"); // RULE3

	property p_window_read;
		@(posedge clk_i) disable iff (rst_i)
		read_status |=> wb_dat_o[measure_pkg::WINDOW_BIT] == $past(flag_sync_w[1]);
	endproperty
	a_window_read: assert property (p_window_read) else $error("window bit read wrong"); // RULE5

	// Each flag follows its input two edges late, rising and falling alike
	property p_window_fall;
		@(posedge clk_i) disable iff (rst_i)
		$fell(flag_i.window_open) ##1 !flag_i.window_open |=> !flag_sync_w[1];
	endproperty
	a_window_fall: assert property (p_window_fall) else $error("window flag stuck"); // RULE5

	property p_active_rise;
		@(posedge clk_i) disable iff (rst_i)
		$rose(flag_i.count_active) ##1 flag_i.count_active |=> flag_sync_w[2];
	endproperty
	a_active_rise: assert property (p_active_rise) else $error("active flag lags"); // RULE4

	property p_active_fall;
		@(posedge clk_i) disable iff (rst_i)
		$fell(flag_i.count_active) ##1 !flag_i.count_active |=> !flag_sync_w[2];
	endproperty
	a_active_fall: assert property (p_active_fall) else $error("active flag stuck"); // RULE4

	property p_acq_rise;
		@(posedge clk_i) disable iff (rst_i)
		$rose(flag_i.acquire_active) ##1 flag_i.acquire_active |=> flag_sync_w[0];
	endproperty
	a_acq_rise: assert property (p_acq_rise) else $error("acquire flag lags"); // RULE6

	property p_acq_fall;
		@(posedge clk_i) disable iff (rst_i)
		$fell(flag_i.acquire_active) ##1 !flag_i.acquire_active |=> !flag_sync_w[0];
	endproperty
	a_acq_fall: assert property (p_acq_fall) else $error("acquire flag stuck"); // RULE6

	// The completion view shows the done lines as they stood at the taken edge
	property p_complete_view;
		@(posedge clk_i) disable iff (rst_i)
		read_complete |=>
			wb_dat_o[measure_pkg::PERIOD_REQ_BIT] == $past(done_i.period_done);
	endproperty
	a_complete_view: assert property (p_complete_view) else $error("done view wrong"); // RULE1

	// Reset leaves no request pending and no answer on the bus
	property p_reset_zero;
		@(posedge clk_i)
		rst_i |=> req_o == '0 && !wb_ack_o && !wb_err_o;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("reset left state"); // RULE7

endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clk_i, rst_i, cyc, stb, we, ack, err;
	logic [3:0] adr, sel;
	logic [31:0] dat, dat_o;
	measure_pkg::done_s done;
	measure_pkg::flag_s flag;
	measure_pkg::req_s req;
	logic [31:0] exp_q[$];
	logic [31:0] rng = 32'hB32F;
	logic [3:0] sel_v = 4'hF;
	int fails = 0;
	int total_checks = 0;
	int cyc_n = 0;

	measure_timer_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .wb_err_o(err), .done_i(done), .flag_i(flag), .req_o(req));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic give_verdict();
		if (fails == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One classic cycle; entered right after a rising edge, ends after one idle cycle
	// It waits for the answer with no limit of its own; the hang guard ends a lost one
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic e);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= sel_v;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1 && err !== 1'b1);
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic x;
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0, x);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Read data is judged at the ack edge against the oldest note
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			chk("rdata", exp_q.pop_front(), dat_o);
		end
	end

	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			fails++;
			give_verdict();
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic e;
		rst_i = 1'b1;
		{cyc, stb, we, adr, sel, dat} = '0;
		done = '0;
		flag = '0;
		for (int r = 0; r < 2; r++) begin
			repeat (16) @(posedge clk_i);
			rst_i <= 1'b0;
			@(posedge clk_i);
			rd(4'h0, 32'h0);
			bus(1'b1, 4'h0, 32'hFF, e);
			chk("req", 32'h7, {29'h0, req});
			bus(1'b1, 4'h0, 32'h0, e);
			rd(4'h0, 32'hE0);
			rst_i <= (r == 0);
		end
		// Completions retire one request at a time, the others stay pending
		for (int i = 0; i < 3; i++) begin
			done <= measure_pkg::done_s'(3'b100 >> i);
			@(posedge clk_i);
			done <= '0;
			repeat (2) @(posedge clk_i);
			chk("req", 32'h7 >> (i + 1), {29'h0, req});
			rd(4'h0, (32'h7 >> (i + 1)) << 5);
		end
		// Writes off byte lane 0 or to the completion view change nothing
		sel_v = 4'hE;
		bus(1'b1, 4'h0, 32'hE0, e);
		sel_v = 4'hF;
		bus(1'b1, 4'h4, 32'hE0, e);
		chk("req", 32'h0, {29'h0, req});
		// Completion view shows the done lines as they stand
		done <= measure_pkg::done_s'(3'b101);
		rd(4'h4, 32'hA0);
		// A write meeting a completion in the same cycle still sets the bit
		done <= measure_pkg::done_s'(3'b100);
		fork
			bus(1'b1, 4'h0, 32'h80, e);
			begin
				@(posedge clk_i);
				done <= '0;
			end
		join
		chk("req", 32'h4, {29'h0, req});
		done <= measure_pkg::done_s'(3'b100);
		@(posedge clk_i);
		done <= '0;
		@(posedge clk_i);
		chk("req", 32'h0, {29'h0, req});
		// Flags cross two flops, so allow four cycles before reading
		for (int i = 0; i < 8; i++) begin
			rng = xs(rng);
			flag <= measure_pkg::flag_s'(rng[2:0]);
			repeat (4) @(posedge clk_i);
			rd(4'h0, {29'h0, rng[2:0]});
		end
		bus(1'b0, 4'h8, 32'h0, e);
		chk("err", 32'h1, {31'h0, e});
		chk("pending", 32'h0, exp_q.size());
		give_verdict();
	end
endmodule
